/* File: odtmt_defs.svh */
// odtmt_defs.svh: clock period, reset values and timing counts of the odt mode transition tracker
// assumes a 100 MHz device command clock; included by its bare name
`ifndef ODTMT_DEFS_SVH
`define ODTMT_DEFS_SVH

// =====================================================================
// clock
`define ODTMT_CLK_PERIOD_PS        10000

// =====================================================================
// asynchronous termination delays, picoseconds as printed in ns
`define ODTMT_ASYNC_ON_MIN_PS      2000
`define ODTMT_ASYNC_ON_MAX_PS      8500
`define ODTMT_ASYNC_OFF_MIN_PS     2000
`define ODTMT_ASYNC_OFF_MAX_PS     8500
// least time rounds up, at least one cycle
`define ODTMT_ASYNC_MIN_CYC        (((`ODTMT_ASYNC_ON_MIN_PS + `ODTMT_CLK_PERIOD_PS - 1) / `ODTMT_CLK_PERIOD_PS) < 1 ? 1 : \
                                    ((`ODTMT_ASYNC_ON_MIN_PS + `ODTMT_CLK_PERIOD_PS - 1) / `ODTMT_CLK_PERIOD_PS))
// longest time rounds down, at least one cycle
`define ODTMT_ASYNC_MAX_CYC        ((`ODTMT_ASYNC_ON_MAX_PS / `ODTMT_CLK_PERIOD_PS) < 1 ? 1 : \
                                    (`ODTMT_ASYNC_ON_MAX_PS / `ODTMT_CLK_PERIOD_PS))

// =====================================================================
// default cycle counts
`define ODTMT_WRITE_LATENCY        5
`define ODTMT_CPDED_CYC            1
`define ODTMT_RFC_CYC              16
`define ODTMT_XPDLL_CYC            24
`define ODTMT_CNT_W                8

// =====================================================================
// reset values
`define ODTMT_CKE_RST              1'b1
`define ODTMT_ODT_RST              1'b0

`endif

/* File: odtmt_pkg.sv */
// odtmt_pkg.sv: types of the odt mode transition tracker, sequencing states for the controller end, response kind for the device end
// assumes nothing beyond the compile order
package odtmt_pkg;

   // =====================================================================
   // controller sequencing states
   typedef enum logic [1:0] {
      ODTMT_IDLE,
      ODTMT_ENTER_LEAD,
      ODTMT_PDOWN,
      ODTMT_EXIT_LEAD
   } odtmt_ctrl_state_type;

   // termination response kind of the device
   typedef enum logic {
      ODTMT_RESP_SYNC,
      ODTMT_RESP_ASYNC
   } odtmt_resp_type;

endpackage

/* File: odtmt_link_if.sv */
// odtmt_link_if.sv: wires between memory controller and memory device
// assumes both ends sit on the same device command clock
`timescale 1ns/1ps

interface odtmt_link_if;

   // =====================================================================
   // link signals
   logic cke;            // clock enable, low in power-down
   logic odt;            // termination request pin
   logic refresh_cmd;    // one-cycle refresh command strobe

   // controller end drives
   modport ctrl (
      output cke,
      output odt,
      output refresh_cmd
   );

   // device end samples
   modport dram (
      input  cke,
      input  odt,
      input  refresh_cmd
   );

endinterface

/* File: odtmt_ctrl.sv */
// odtmt_ctrl.sv: controller end, drives cke, odt and refresh and tracks transition periods
// assumes the device end on the same clock; user side is synchronous logic
`timescale 1ns/1ps
`include "odtmt_defs.svh"

module odtmt_ctrl #(
   parameter int WRITE_LATENCY = `ODTMT_WRITE_LATENCY,
   parameter int CPDED_CYC     = `ODTMT_CPDED_CYC,
   parameter int RFC_CYC       = `ODTMT_RFC_CYC,
   parameter int XPDLL_CYC     = `ODTMT_XPDLL_CYC,
   parameter int CNT_W         = `ODTMT_CNT_W
) (
   // clock and reset
   input  wire logic   clock,
   input  wire logic   sys_rst,
   input  wire logic   clk_en,
   // link
   odtmt_link_if.ctrl  link,
   // user requests
   input  wire logic   dll_frozen,
   input  wire logic   pd_req,
   input  wire logic   refresh_req,
   input  wire logic   odt_req,
   // user status
   output logic        odt_uncertain,
   output logic        pd_active,
   output logic        refresh_busy
);

   localparam logic [CNT_W-1:0] LEAD_CNT  = CNT_W'(WRITE_LATENCY - 1);
   localparam logic [CNT_W-1:0] CPDED_CNT = CNT_W'(CPDED_CYC);
   localparam logic [CNT_W-1:0] RFC_CNT   = CNT_W'(RFC_CYC);
   localparam logic [CNT_W-1:0] XPDLL_CNT = CNT_W'(XPDLL_CYC);

   odtmt_pkg::odtmt_ctrl_state_type state_ff;
   odtmt_pkg::odtmt_ctrl_state_type nxt_state;
   logic [CNT_W-1:0]                lead_ff;
   logic [CNT_W-1:0]                nxt_lead;
   logic [CNT_W-1:0]                tail_ff;
   logic [CNT_W-1:0]                nxt_tail;
   logic [CNT_W-1:0]                rfc_ff;
   logic [CNT_W-1:0]                nxt_rfc;
   logic                            cke_ff;
   logic                            nxt_cke;
   logic                            odt_ff;
   logic                            refresh_ff;
   logic                            unc_ff;
   logic                            nxt_unc;
   logic                            lead_done;
   logic                            refresh_go;
   logic [CNT_W-1:0]                entry_tail;

   // =====================================================================
   // decode
   assign lead_done  = (lead_ff <= 1);
   assign refresh_go = refresh_req && (state_ff == odtmt_pkg::ODTMT_IDLE) && !pd_req;
   assign entry_tail = (rfc_ff > CPDED_CNT) ? rfc_ff : CPDED_CNT;
   assign nxt_rfc    = refresh_go ? RFC_CNT : ((rfc_ff != 0) ? rfc_ff - 1'b1 : rfc_ff);

   // sequencing of cke around power-down
   always_comb begin
      nxt_state = state_ff;
      nxt_lead  = (lead_ff != 0) ? lead_ff - 1'b1 : lead_ff;
      nxt_tail  = (tail_ff != 0) ? tail_ff - 1'b1 : tail_ff;
      nxt_cke   = cke_ff;
      unique case (state_ff)
         odtmt_pkg::ODTMT_IDLE: begin
            if (pd_req && !refresh_req) begin
               nxt_state = odtmt_pkg::ODTMT_ENTER_LEAD;
               nxt_lead  = LEAD_CNT;
            end
         end
         odtmt_pkg::ODTMT_ENTER_LEAD: begin
            if (lead_done) begin
               nxt_state = odtmt_pkg::ODTMT_PDOWN;
               nxt_cke   = 1'b0;
               // one extra cycle, the device registers cke an edge later
               nxt_tail  = entry_tail + 1'b1;
            end
         end
         odtmt_pkg::ODTMT_PDOWN: begin
            if (!pd_req) begin
               nxt_state = odtmt_pkg::ODTMT_EXIT_LEAD;
               nxt_lead  = LEAD_CNT;
            end
         end
         odtmt_pkg::ODTMT_EXIT_LEAD: begin
            if (lead_done) begin
               nxt_state = odtmt_pkg::ODTMT_IDLE;
               nxt_cke   = 1'b1;
               // one extra cycle, the device registers cke an edge later
               nxt_tail  = XPDLL_CNT + 1'b1;
            end
         end
      endcase
   end

   assign nxt_unc = dll_frozen && ((nxt_state == odtmt_pkg::ODTMT_ENTER_LEAD) ||
                                   (nxt_state == odtmt_pkg::ODTMT_EXIT_LEAD) || (nxt_tail != 0));

   // state registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff   <= odtmt_pkg::ODTMT_IDLE;
         lead_ff    <= '0;
         tail_ff    <= '0;
         rfc_ff     <= '0;
         cke_ff     <= `ODTMT_CKE_RST;
         odt_ff     <= `ODTMT_ODT_RST;
         refresh_ff <= 1'b0;
         unc_ff     <= 1'b0;
      end else if (clk_en) begin
         state_ff   <= nxt_state;
         lead_ff    <= nxt_lead;
         tail_ff    <= nxt_tail;
         rfc_ff     <= nxt_rfc;
         cke_ff     <= nxt_cke;
         odt_ff     <= odt_req;
         refresh_ff <= refresh_go;
         unc_ff     <= nxt_unc;
      end
   end

   // outputs from flops
   assign link.cke         = cke_ff;
   assign link.odt         = odt_ff;
   assign link.refresh_cmd = refresh_ff;
   assign odt_uncertain    = unc_ff;
   assign pd_active        = !cke_ff;
   assign refresh_busy     = (rfc_ff != 0);

endmodule

/* File: odtmt_dram.sv */
// odtmt_dram.sv: device end, termination response around precharge power-down with frozen dll
// assumes the controller end on the same clock keeps its own timing; user side shows termination
//
// Overview of operation
// - frozen dll gives transition period at entry
// - entry period starts wl minus one early
// - entry period ends after command pass delay
// - refresh in progress may extend entry period
// - lead start excluded, final clock included
// - turn-on within min and max bounds
// - turn-off within min and max bounds
// - exit period from lead to relock delay
// - synchronous before entry, asynchronous after
// - asynchronous before exit, synchronous after
// - entry then short exit merge periods
// - exit then short entry merge periods
// - asynchronous path ignores additive latency
// - asynchronous change within 2 to 8.5 ns
// - no read or write in power-down
`timescale 1ns/1ps
`include "odtmt_defs.svh"

module odtmt_dram #(
   parameter int WRITE_LATENCY = `ODTMT_WRITE_LATENCY,
   parameter int CPDED_CYC     = `ODTMT_CPDED_CYC,
   parameter int RFC_CYC       = `ODTMT_RFC_CYC,
   parameter int XPDLL_CYC     = `ODTMT_XPDLL_CYC,
   parameter int CNT_W         = `ODTMT_CNT_W
) (
   // clock and reset
   input  wire logic   clock,
   input  wire logic   sys_rst,
   input  wire logic   clk_en,
   // link
   odtmt_link_if.dram  link,
   // mode register zero, bit a12
   input  wire logic   mode_register_zero_a12,
   // termination state
   output logic        rtt_on,
   output logic        async_mode,
   output logic        transition_active,
   output logic        powered_down
);

   // =====================================================================
   // latencies
   localparam int                SYNC_LAT  = WRITE_LATENCY - 2;
   localparam int                ASYNC_LAT = `ODTMT_ASYNC_MIN_CYC;
   localparam logic [CNT_W-1:0]  CPDED_CNT = CNT_W'(CPDED_CYC);
   localparam logic [CNT_W-1:0]  RFC_CNT   = CNT_W'(RFC_CYC);
   localparam logic [CNT_W-1:0]  XPDLL_CNT = CNT_W'(XPDLL_CYC);

   logic [SYNC_LAT:0]           pipe_ff;
   logic [SYNC_LAT:0]           nxt_pipe;
   logic                        cke_ff;
   logic                        rtt_ff;
   logic                        nxt_rtt;
   odtmt_pkg::odtmt_resp_type   resp_ff;
   odtmt_pkg::odtmt_resp_type   nxt_resp;
   logic [CNT_W-1:0]            period_ff;
   logic [CNT_W-1:0]            nxt_period;
   logic [CNT_W-1:0]            rfc_ff;
   logic [CNT_W-1:0]            nxt_rfc;
   logic                        trans_ff;
   logic                        dll_frozen;
   logic                        cke_fall;
   logic                        cke_rise;
   logic [CNT_W-1:0]            entry_len;
   logic                        sync_tap;
   logic                        async_tap;

   // =====================================================================
   // edge decode
   // frozen when a12 is zero
   assign dll_frozen = (mode_register_zero_a12 == 1'b0);
   assign cke_fall   = cke_ff && !link.cke;
   assign cke_rise   = !cke_ff && link.cke;

   // refresh in progress counter, loaded by a refresh command
   assign nxt_rfc = link.refresh_cmd ? RFC_CNT : ((rfc_ff != 0) ? rfc_ff - 1'b1 : rfc_ff);

   assign entry_len = (rfc_ff > CPDED_CNT) ? rfc_ff : CPDED_CNT;

   // period length in cycles, the cke edge cycle counts as the first
   always_comb begin
      nxt_period = (period_ff != 0) ? period_ff - 1'b1 : period_ff;
      if (dll_frozen && cke_fall) begin
         // entry end wins after short idle
         nxt_period = entry_len;
      end else if (dll_frozen && cke_rise) begin
         // exit end wins after short power-down
         nxt_period = XPDLL_CNT;
      end
   end

   // =====================================================================
   // response kind
   always_comb begin
      nxt_resp = resp_ff;
      if (!dll_frozen) begin
         nxt_resp = odtmt_pkg::ODTMT_RESP_SYNC;
      end else if (cke_fall) begin
         nxt_resp = odtmt_pkg::ODTMT_RESP_ASYNC;
      end else if (cke_rise) begin
         nxt_resp = odtmt_pkg::ODTMT_RESP_SYNC;
      end
   end

   // =====================================================================
   // odt delay line, tap 0 is the current sample
   assign nxt_pipe  = {pipe_ff[SYNC_LAT-1:0], link.odt};
   // synchronous turn-on at wl minus 2
   // synchronous turn-off at same latency
   // tap wl minus 2 lands the change wl minus 2 edges after the sampling edge
   assign sync_tap  = nxt_pipe[SYNC_LAT];
   assign async_tap = nxt_pipe[ASYNC_LAT-1];
   // entry lead edges still on sync path, exit lead edges still on async path
   // switch at the cke edge cycle
   assign nxt_rtt   = (nxt_resp == odtmt_pkg::ODTMT_RESP_ASYNC) ? async_tap : sync_tap;

   // state registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pipe_ff   <= '0;
         cke_ff    <= `ODTMT_CKE_RST;
         rtt_ff    <= `ODTMT_ODT_RST;
         resp_ff   <= odtmt_pkg::ODTMT_RESP_SYNC;
         period_ff <= '0;
         rfc_ff    <= '0;
         trans_ff  <= 1'b0;
      end else if (clk_en) begin
         pipe_ff   <= nxt_pipe;
         cke_ff    <= link.cke;
         rtt_ff    <= nxt_rtt;
         resp_ff   <= nxt_resp;
         period_ff <= nxt_period;
         rfc_ff    <= nxt_rfc;
         trans_ff  <= (nxt_period != 0);
      end
   end

   // outputs from flops
   assign rtt_on            = rtt_ff;
   assign async_mode        = (resp_ff == odtmt_pkg::ODTMT_RESP_ASYNC);
   assign transition_active = trans_ff;
   assign powered_down      = !cke_ff;

endmodule

/* File: odtmt_asserts.sv */
// odtmt_asserts.sv: timing checks on the link and both ends of the tracker
// assumes one clock; instantiated beside the link interface
`timescale 1ns/1ps

module odtmt_asserts #(
   parameter int WRITE_LATENCY = 5,
   parameter int RFC_CYC       = 16,
   parameter int XPDLL_CYC     = 24
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // link
   input wire logic cke,
   input wire logic odt,
   input wire logic refresh_cmd,
   // device end
   input wire logic mode_register_zero_a12,
   input wire logic rtt_on,
   input wire logic async_mode,
   input wire logic transition_active,
   input wire logic powered_down,
   // controller end
   input wire logic odt_uncertain
);
   // ====================
   // helper counters
   localparam int LEAD = WRITE_LATENCY - 1;
   wire        frz    = !mode_register_zero_a12;
   logic [7:0] up_ff;
   logic [7:0] rf_ff;
   wire  [7:0] nxt_up = !cke ? 8'h01 : ((up_ff == 8'h00 || up_ff == 8'hff) ? up_ff : up_ff + 8'h01);
   wire  [7:0] nxt_rf = refresh_cmd ? 8'(RFC_CYC) : ((rf_ff == 8'h00) ? rf_ff : rf_ff - 8'h01);

   // edges since cke rose, refresh time left
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         up_ff <= 8'h00;
         rf_ff <= 8'h00;
      end else begin
         up_ff <= nxt_up;
         rf_ff <= nxt_rf;
      end
   end

   // ====================
   // properties on both ends
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_entry_async;
      $fell(cke) && frz |=> async_mode && powered_down;
   endproperty
   a_entry_async: assert property (p_entry_async) else $error("no async mode after entry");
   property p_entry_period;
      $fell(cke) && frz |=> transition_active;
   endproperty
   a_entry_period: assert property (p_entry_period) else $error("no period after entry");
   property p_no_freeze;
      !frz |-> !async_mode && !transition_active;
   endproperty
   a_no_freeze: assert property (p_no_freeze) else $error("async or period with dll running");
   property p_exit_end;
      cke && frz && up_ff == 8'(XPDLL_CYC + 2) |-> !transition_active && $past(transition_active);
   endproperty
   a_exit_end: assert property (p_exit_end) else $error("exit period length wrong");
   property p_refresh_hold;
      !cke && !$past(cke) && frz && rf_ff > 8'h02 |-> transition_active;
   endproperty
   a_refresh_hold: assert property (p_refresh_hold) else $error("period ended during refresh");
   property p_lead;
      $rose(odt_uncertain) |-> ##LEAD cke != $past(cke);
   endproperty
   a_lead: assert property (p_lead) else $error("cke edge not after lead");
   property p_sync_lat;
      cke && up_ff > 8'(WRITE_LATENCY) && !transition_active |-> rtt_on == $past(odt, LEAD);
   endproperty
   a_sync_lat: assert property (p_sync_lat) else $error("sync termination latency wrong");
   property p_async_lat;
      !cke && !$past(cke) && frz |-> rtt_on == $past(odt);
   endproperty
   a_async_lat: assert property (p_async_lat) else $error("async termination delay wrong");
   cover property ($fell(cke) && frz);
   cover property (cke && up_ff == 8'(XPDLL_CYC + 2));
   cover property ($fell(cke) && rf_ff > 8'h02);
endmodule

/* File: test_odt_mode_transition_tracker.sv */
// test_odt_mode_transition_tracker.sv: self-checking bench, controller end facing device end
// assumes design files and odtmt_asserts.sv compile first
`timescale 1ns/1ps

module test_odt_mode_transition_tracker;
   // ====================
   // shortened relock count, default wl and refresh counts, and table
   localparam int WL = 5;
   localparam int RF = 16;
   localparam int XP = 6;
   typedef struct {logic odt; logic pd; int wt; logic rtt; logic pdn; logic asy;} odtmt_row_type;
   odtmt_row_type rows [6] = '{'{1'h1, 1'h0, 12, 1'h1, 1'h0, 1'h0}, '{1'h0, 1'h0, 12, 1'h0, 1'h0, 1'h0},
      '{1'h0, 1'h1, 20, 1'h0, 1'h1, 1'h1}, '{1'h1, 1'h1, 6, 1'h1, 1'h1, 1'h1},
      '{1'h0, 1'h1, 6, 1'h0, 1'h1, 1'h1}, '{1'h1, 1'h0, 30, 1'h1, 1'h0, 1'h0}};
   logic clock, sys_rst, clk_en, dll_frozen, pd_req, refresh_req, odt_req, a12, pu, pt;
   logic odt_uncertain, pd_active, refresh_busy, rtt_on, async_mode, transition_active, powered_down;
   int   err_total, num_checks, cyc, n, ru, rt, nt;

   // ====================
   // both ends on one link
   odtmt_link_if u_odtmt_link_if ();
   wire cke = u_odtmt_link_if.cke;
   wire odt = u_odtmt_link_if.odt;
   odtmt_ctrl #(.WRITE_LATENCY(WL), .RFC_CYC(RF), .XPDLL_CYC(XP)) u_odtmt_ctrl (.clock(clock), .sys_rst(sys_rst),
      .clk_en(clk_en), .link(u_odtmt_link_if), .dll_frozen(dll_frozen), .pd_req(pd_req), .refresh_req(refresh_req),
      .odt_req(odt_req), .odt_uncertain(odt_uncertain), .pd_active(pd_active), .refresh_busy(refresh_busy));
   odtmt_dram #(.WRITE_LATENCY(WL), .RFC_CYC(RF), .XPDLL_CYC(XP)) u_odtmt_dram (.clock(clock), .sys_rst(sys_rst),
      .clk_en(clk_en), .link(u_odtmt_link_if), .mode_register_zero_a12(a12), .rtt_on(rtt_on),
      .async_mode(async_mode), .transition_active(transition_active), .powered_down(powered_down));
   odtmt_asserts #(.WRITE_LATENCY(WL), .RFC_CYC(RF), .XPDLL_CYC(XP)) u_odtmt_asserts (.clock(clock),
      .sys_rst(sys_rst), .cke(cke), .odt(odt), .refresh_cmd(u_odtmt_link_if.refresh_cmd),
      .mode_register_zero_a12(a12), .rtt_on(rtt_on), .async_mode(async_mode),
      .transition_active(transition_active), .powered_down(powered_down), .odt_uncertain(odt_uncertain));

   // ====================
   // compare, wait and report tasks
   task automatic chk(string nm, logic exp, logic got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic chk_cnt(string nm, int exp, int got);
      num_checks++;
      if (got != exp) begin
         err_total++;
         $display("mismatch %s expected %0d seen %0d", nm, exp, got);
      end
   endtask
   // counts rises and high cycles over k edges
   task automatic watch(int k);
      {ru, rt, nt} = {32'h0, 32'h0, 32'h0};
      {pu, pt} = {odt_uncertain, transition_active};
      repeat (k) begin
         @(posedge clock);
         ru += int'(odt_uncertain === 1'h1 && pu !== 1'h1);
         rt += int'(transition_active === 1'h1 && pt !== 1'h1);
         nt += int'(transition_active === 1'h1);
         {pu, pt} = {odt_uncertain, transition_active};
      end
   endtask
   task automatic wait_cke(logic v);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (cke !== v && n < 60);
   endtask
   task automatic fin(string s);
      $display("test %s done", s);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // clock
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   // hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         $display("timeout at cycle %0d", cyc);
         summarize();
      end
   end

   // ====================
   // main sequence
   initial begin
      {sys_rst, clk_en, dll_frozen, a12, pd_req, refresh_req, odt_req} = 7'h70;
      repeat (16) @(posedge clock);
      sys_rst <= 1'h0;
      foreach (rows[i]) begin
         odt_req <= rows[i].odt;
         pd_req  <= rows[i].pd;
         repeat (rows[i].wt) @(posedge clock);
         chk("rtt_on", rows[i].rtt, rtt_on);
         chk("powered_down", rows[i].pdn, powered_down);
         chk("pd_active", rows[i].pdn, pd_active);
         chk("async_mode", rows[i].asy, async_mode);
      end
      fin("table");
      pd_req <= 1'h1;
      wait_cke(1'h0);
      chk_cnt("entry lead", WL + 1, n);
      watch(20);
      chk_cnt("entry period", 1, nt);
      refresh_req <= 1'h1;
      watch(1);
      refresh_req <= 1'h0;
      watch(4);
      chk("refresh_busy", 1'h0, refresh_busy);
      pd_req <= 1'h0;
      watch(40);
      chk_cnt("exit period", XP, nt);
      fin("entry exit");
      refresh_req <= 1'h1;
      watch(1);
      refresh_req <= 1'h0;
      pd_req <= 1'h1;
      wait_cke(1'h0);
      watch(30);
      chk("refresh period", 1'h1, nt >= RF - 7 && nt <= RF - 4);
      pd_req <= 1'h0;
      wait_cke(1'h1);
      pd_req <= 1'h1;
      watch(40);
      chk_cnt("short idle rises", 0, ru + rt - 1);
      pd_req <= 1'h0;
      wait_cke(1'h1);
      watch(30);
      pd_req <= 1'h1;
      wait_cke(1'h0);
      pd_req <= 1'h0;
      watch(40);
      chk_cnt("short pd rises", 0, ru);
      fin("refresh and overlap");
      {a12, dll_frozen, pd_req} <= 3'h5;
      watch(30);
      chk("dll running pd", 1'h1, powered_down);
      chk_cnt("dll running period", 0, nt + ru);
      {a12, dll_frozen, pd_req} <= 3'h4;
      watch(30);
      {a12, dll_frozen, odt_req} <= 3'h3;
      watch(10);
      {clk_en, odt_req} <= 2'h0;
      watch(6);
      chk("frozen odt", 1'h1, odt);
      chk("frozen rtt", 1'h1, rtt_on);
      clk_en <= 1'h1;
      watch(10);
      chk("rtt_on", 1'h0, rtt_on);
      odt_req <= 1'h1;
      watch(10);
      sys_rst <= 1'h1;
      watch(4);
      chk("reset rtt", 1'h0, rtt_on);
      chk("reset cke", 1'h1, cke);
      sys_rst <= 1'h0;
      watch(1);
      chk("odt at release", 1'h0, odt);
      fin("freeze and reset");
      summarize();
   end
endmodule
